// file: rtl/sfscd_pkg.sv
// Constants and carriers shared by the serial flash status and command decoder.
package sfscd_pkg;
   // ************************************************************
   // Instruction opcodes
   // ************************************************************
   localparam logic [7:0] READ_CMD = 8'h03;
   localparam logic [7:0] FAST_READ_CMD = 8'h0B;
   localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
   localparam logic [7:0] BLK32_ERASE_CMD = 8'h52;
   localparam logic [7:0] BLK64_ERASE_CMD = 8'hD8;
   localparam logic [7:0] CHIP_ERASE_A_CMD = 8'h60;
   localparam logic [7:0] CHIP_ERASE_B_CMD = 8'hC7;
   localparam logic [7:0] BYTE_PROG_CMD = 8'h02;
   localparam logic [7:0] AAI_WORD_CMD = 8'hAD;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] STATUS_WRITE_UNLOCK_CMD = 8'h50;
   localparam logic [7:0] LATCH_SET_CMD = 8'h06;
   localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;
   localparam logic [7:0] SO_READY_SIGNAL_ON_CMD = 8'h70;
   localparam logic [7:0] SO_READY_SIGNAL_OFF_CMD = 8'h80;
   // ************************************************************
   // Frame lengths in whole bytes, opcode included
   // ************************************************************
   localparam logic [2:0] LEN_OPCODE = 3'h1;
   localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
   localparam logic [2:0] LEN_AAI_NEXT = 3'h3;
   localparam logic [2:0] LEN_ERASE = 3'h4;
   localparam logic [2:0] LEN_BYTE_PROG = 3'h5;
   localparam logic [2:0] LEN_AAI_FIRST = 3'h6;
   localparam logic [2:0] LEN_SATURATE = 3'h7;
   // ************************************************************
   // Status register layout and power-up value
   // ************************************************************
   localparam int ST_BUSY = 0;
   localparam int ST_AAI = 6;
   localparam logic [3:0] PROTECT_RESET = 4'h7;
   localparam logic [7:0] STATUS_RESET = 8'h1C;
   // ************************************************************
   // Array geometry
   // ************************************************************
   localparam logic [20:0] ARRAY_TOP = 21'h1FFFFF;
   localparam logic [20:0] SECTOR_MASK = 21'h000FFF;
   localparam logic [20:0] BLK32_MASK = 21'h007FFF;
   localparam logic [20:0] BLK64_MASK = 21'h00FFFF;
   localparam logic [20:0] WORD_STEP = 21'h000002;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CORE_CLK_MHZ = 100;
   localparam int PROG_TIME_NS = 10000;
   localparam int ERASE_TIME_US = 25000;
   localparam int CHIP_ERASE_TIME_US = 50000;
   localparam int PROG_CYCLES_DEF = (PROG_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int ERASE_CYCLES_DEF = ERASE_TIME_US * CORE_CLK_MHZ;
   localparam int CHIP_ERASE_CYCLES_DEF = CHIP_ERASE_TIME_US * CORE_CLK_MHZ;
   localparam int TIMER_W = 23;
   // ************************************************************
   // Array operation kinds, one-hot apart from OPK_NONE
   // ************************************************************
   typedef enum logic [6:0] {
      OPK_NONE = 7'h00,
      OPK_BYTE = 7'h01,
      OPK_AAI = 7'h02,
      OPK_SECTOR = 7'h04,
      OPK_BLK32 = 7'h08,
      OPK_BLK64 = 7'h10,
      OPK_CHIP = 7'h20,
      OPK_SPARE = 7'h40
   } sfscd_opk_type;
   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic valid;
      sfscd_opk_type kind;
      logic [20:0] addr;
      logic [15:0] data;
   } sfscd_req_type;
   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [2:0] byte_cnt;
      logic [6:0] shift;
   } sfscd_cnt_type;
   typedef struct packed {
      logic tgl;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] d0;
      logic [7:0] d1;
      logic [2:0] nbytes;
      logic partial;
      logic busy_m;
      logic busy_s;
   } sfscd_res_type;
   typedef struct packed {
      logic so;
      logic oe;
      logic [2:0] idx;
   } sfscd_out_type;
endpackage : sfscd_pkg

// file: rtl/sfscd_top.sv
// Status register, block protection and instruction decoder of the serial flash.
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// ************************************************************
module sfscd_top
   import sfscd_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF,
   parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DEF,
   parameter int unsigned CHIP_ERASE_CYCLES = CHIP_ERASE_CYCLES_DEF
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic wp_n,
   output logic so_out,
   output logic so_oe,
   output var sfscd_req_type array_req,
   output logic [7:0] status_out
);

   // ************************************************************
   // Core state
   // ************************************************************
   typedef struct packed {
      logic cs_m;
      logic cs_s;
      logic tgl_m;
      logic tgl_s;
      logic tgl_seen;
      logic wp_m;
      logic wp_s;
      logic busy;
      logic write_latch_flag;
      logic [3:0] protect_level;
      logic auto_increment_mode;
      logic protect_lock_bit;
      logic unlock;
      logic hw_ready_en;
      logic aai_exit;
      sfscd_opk_type kind;
      logic [20:0] aai_addr;
      logic [TIMER_W-1:0] timer;
      logic [7:0] snap;
      logic snap_hw;
      logic [7:0] device_status_and_protect;
      sfscd_req_type req;
   } sfscd_core_type;

   localparam sfscd_core_type CORE_RESET = '{
      cs_m: 1'b1,
      cs_s: 1'b1,
      wp_m: 1'b1,
      wp_s: 1'b1,
      protect_level: PROTECT_RESET,
      kind: OPK_NONE,
      snap: STATUS_RESET,
      device_status_and_protect: STATUS_RESET,
      default: '0
   };

   logic [1:0] rst_sync_r;
   logic rst_core_n;
   sfscd_core_type core_r;
   sfscd_core_type core_nxt;
   sfscd_cnt_type cnt_r;
   sfscd_cnt_type cnt_nxt;
   sfscd_res_type res_r;
   sfscd_res_type res_nxt;
   sfscd_out_type out_r;
   sfscd_out_type out_nxt;

   // ************************************************************
   // Reset release
   // ************************************************************
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_sync_r <= 2'h0;
      end
      else
      begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_core_n = rst_sync_r[1];

   // ************************************************************
   // Link side, rising edge: byte assembly
   // ************************************************************
   // The counters restart with every frame, while the captured frame stays
   // intact after select rises so the core can read it at leisure.
   always_comb
   begin
      logic [7:0] byte_in;
      cnt_nxt = cnt_r;
      res_nxt = res_r;
      byte_in = {cnt_r.shift, si};
      cnt_nxt.shift = byte_in[6:0];
      cnt_nxt.bit_cnt = cnt_r.bit_cnt + 3'h1;
      res_nxt.busy_m = core_r.busy;
      res_nxt.busy_s = res_r.busy_m;
      // The frame flag toggles only once a whole opcode is in, and the length
      // fields move only inside a frame, so clock edges while deselected, such
      // as a change of idle level, cannot spoil a frame not yet executed.
      if (cnt_r.bit_cnt == 3'h7 && cnt_r.byte_cnt == 3'h0)
      begin
         res_nxt.tgl = ~res_r.tgl;
      end
      if (cnt_r.bit_cnt == 3'h7)
      begin
         if (cnt_r.byte_cnt != LEN_SATURATE)
         begin
            cnt_nxt.byte_cnt = cnt_r.byte_cnt + 3'h1;
         end
         case (cnt_r.byte_cnt)
            3'h0: res_nxt.opcode = byte_in;
            3'h1: res_nxt.addr[23:16] = byte_in;
            3'h2: res_nxt.addr[15:8] = byte_in;
            3'h3: res_nxt.addr[7:0] = byte_in;
            3'h4: res_nxt.d0 = byte_in;
            3'h5: res_nxt.d1 = byte_in;
            default: ;
         endcase
      end
      if (cnt_r.bit_cnt != 3'h0 || cnt_r.byte_cnt != 3'h0)
      begin
         res_nxt.nbytes = cnt_nxt.byte_cnt;
         res_nxt.partial = (cnt_nxt.bit_cnt != 3'h0);
      end
   end

   always_ff @(posedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge sck or negedge arst_n)
   begin
      if (!arst_n)
      begin
         res_r <= '0;
      end
      else
      begin
         res_r <= res_nxt;
      end
   end

   // ************************************************************
   // Link side, falling edge: serial output
   // ************************************************************
   // The status snapshot is frozen by the core while select is low; only
   // the busy bit is followed live, through its own synchroniser.
   always_comb
   begin
      logic [7:0] stat_live;
      out_nxt = out_r;
      stat_live = {core_r.snap[7:1], res_r.busy_s};
      if (core_r.snap_hw && core_r.snap[ST_AAI])
      begin
         out_nxt.oe = 1'b1;
         out_nxt.so = ~res_r.busy_s;
      end
      else if (cnt_r.byte_cnt != 3'h0 && res_r.opcode == STATUS_READ_CMD)
      begin
         out_nxt.oe = 1'b1;
         out_nxt.so = stat_live[3'h7 - out_r.idx];
         out_nxt.idx = out_r.idx + 3'h1;
      end
      else
      begin
         out_nxt.oe = 1'b0;
      end
   end

   always_ff @(negedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         out_r <= '0;
      end
      else
      begin
         out_r <= out_nxt;
      end
   end

   // ************************************************************
   // Core: protection and operation-start helpers
   // ************************************************************
   function automatic logic [21:0] prot_base(input logic [2:0] lvl);
      logic [21:0] b;
      case (lvl)
         3'h0: b = 22'h200000;
         3'h1: b = 22'h1F0000;
         3'h2: b = 22'h1E0000;
         3'h3: b = 22'h1C0000;
         3'h4: b = 22'h180000;
         3'h5: b = 22'h100000;
         default: b = 22'h000000;
      endcase
      return b;
   endfunction : prot_base

   function automatic sfscd_core_type start_op(
      input sfscd_core_type c,
      input sfscd_opk_type k,
      input logic [TIMER_W-1:0] t,
      input logic [20:0] a,
      input logic [15:0] d
   );
      sfscd_core_type n;
      n = c;
      n.busy = 1'b1;
      n.kind = k;
      n.timer = t;
      n.req.valid = 1'b1;
      n.req.kind = k;
      n.req.addr = a;
      n.req.data = d;
      return n;
   endfunction : start_op

   // ************************************************************
   // Core: status, protection and command execution
   // ************************************************************
   always_comb
   begin
      logic frame_new;
      logic [7:0] op;
      logic [20:0] a;
      logic [20:0] nxt_addr;
      logic [21:0] base;
      logic write_ok;
      frame_new = 1'b0;
      op = res_r.opcode;
      a = res_r.addr[20:0];
      nxt_addr = '0;
      base = prot_base(core_r.protect_level[2:0]);
      write_ok = res_r.nbytes == LEN_OPCODE;
      core_nxt = core_r;
      core_nxt.cs_m = cs_n;
      core_nxt.cs_s = core_r.cs_m;
      core_nxt.tgl_m = res_r.tgl;
      core_nxt.tgl_s = core_r.tgl_m;
      core_nxt.wp_m = wp_n;
      core_nxt.wp_s = core_r.wp_m;
      core_nxt.req.valid = 1'b0;
      if (core_r.cs_s)
      begin
         core_nxt.snap = core_r.device_status_and_protect;
         core_nxt.snap_hw = core_r.hw_ready_en;
      end
      if (core_r.busy)
      begin
         if (core_r.timer == '0)
         begin
            core_nxt.busy = 1'b0;
            core_nxt.kind = OPK_NONE;
            if (core_r.kind != OPK_AAI)
            begin
               core_nxt.write_latch_flag = 1'b0;
            end
            if (core_r.aai_exit)
            begin
               core_nxt.auto_increment_mode = 1'b0;
               core_nxt.write_latch_flag = 1'b0;
               core_nxt.aai_exit = 1'b0;
            end
         end
         else
         begin
            core_nxt.timer = core_r.timer - 1'b1;
         end
      end
      // A frame is acted on once select is seen high and the link has
      // flagged a fresh frame.
      frame_new = core_r.cs_s && (core_r.tgl_s != core_r.tgl_seen);
      if (frame_new)
      begin
         core_nxt.tgl_seen = core_r.tgl_s;
      end
      // Busy frames and torn bytes fall through untouched.
      if (frame_new && !res_r.partial && !core_r.busy)
      begin
         if (core_r.auto_increment_mode && op != AAI_WORD_CMD && op != LATCH_CLEAR_CMD)
         begin
            core_nxt.tgl_seen = core_r.tgl_s;
         end
         else
         begin
            case (op)
               LATCH_SET_CMD:
               begin
                  if (write_ok)
                  begin
                     core_nxt.write_latch_flag = 1'b1;
                  end
               end
               LATCH_CLEAR_CMD:
               begin
                  if (write_ok)
                  begin
                     core_nxt.write_latch_flag = 1'b0;
                     core_nxt.auto_increment_mode = 1'b0;
                  end
               end
               STATUS_WRITE_UNLOCK_CMD:
               begin
                  if (write_ok)
                  begin
                     core_nxt.unlock = 1'b1;
                  end
               end
               STATUS_WRITE_CMD:
               begin
                  if (res_r.nbytes == LEN_STATUS_WRITE && (core_r.write_latch_flag || core_r.unlock))
                  begin
                     if (core_r.wp_s || !core_r.protect_lock_bit)
                     begin
                        core_nxt.protect_level = res_r.addr[21:18];
                        core_nxt.protect_lock_bit = res_r.addr[23];
                     end
                     core_nxt.write_latch_flag = 1'b0;
                     core_nxt.unlock = 1'b0;
                  end
               end
               BYTE_PROG_CMD:
               begin
                  if (res_r.nbytes == LEN_BYTE_PROG && core_r.write_latch_flag && {1'b0, a} < base)
                  begin
                     core_nxt = start_op(core_nxt, OPK_BYTE, TIMER_W'(PROG_CYCLES - 1), a, {res_r.d0, 8'h00});
                  end
               end
               AAI_WORD_CMD:
               begin
                  if (!core_r.auto_increment_mode)
                  begin
                     nxt_addr = {a[20:1], 1'b0};
                     if (res_r.nbytes >= LEN_AAI_FIRST && core_r.write_latch_flag && {1'b0, nxt_addr} < base)
                     begin
                        core_nxt = start_op(core_nxt, OPK_AAI, TIMER_W'(PROG_CYCLES - 1), nxt_addr,
                                            {res_r.d0, res_r.d1});
                        core_nxt.auto_increment_mode = 1'b1;
                        core_nxt.aai_addr = nxt_addr;
                        core_nxt.aai_exit = (nxt_addr == (ARRAY_TOP - 21'h1)) ||
                                            ({1'b0, nxt_addr + WORD_STEP} >= base);
                     end
                  end
                  else if (res_r.nbytes == LEN_AAI_NEXT)
                  begin
                     // Data bytes of a continuation land where address bytes would.
                     nxt_addr = core_r.aai_addr + WORD_STEP;
                     core_nxt = start_op(core_nxt, OPK_AAI, TIMER_W'(PROG_CYCLES - 1), nxt_addr,
                                         res_r.addr[23:8]);
                     core_nxt.aai_addr = nxt_addr;
                     core_nxt.aai_exit = (nxt_addr == (ARRAY_TOP - 21'h1)) ||
                                         ({1'b0, nxt_addr + WORD_STEP} >= base);
                  end
               end
               SECTOR_ERASE_CMD:
               begin
                  if (res_r.nbytes == LEN_ERASE && core_r.write_latch_flag && {1'b0, a | SECTOR_MASK} < base)
                  begin
                     core_nxt = start_op(core_nxt, OPK_SECTOR, TIMER_W'(ERASE_CYCLES - 1), a & ~SECTOR_MASK,
                                         16'h0000);
                  end
               end
               BLK32_ERASE_CMD:
               begin
                  if (res_r.nbytes == LEN_ERASE && core_r.write_latch_flag && {1'b0, a | BLK32_MASK} < base)
                  begin
                     core_nxt = start_op(core_nxt, OPK_BLK32, TIMER_W'(ERASE_CYCLES - 1), a & ~BLK32_MASK,
                                         16'h0000);
                  end
               end
               BLK64_ERASE_CMD:
               begin
                  if (res_r.nbytes == LEN_ERASE && core_r.write_latch_flag && {1'b0, a | BLK64_MASK} < base)
                  begin
                     core_nxt = start_op(core_nxt, OPK_BLK64, TIMER_W'(ERASE_CYCLES - 1), a & ~BLK64_MASK,
                                         16'h0000);
                  end
               end
               CHIP_ERASE_A_CMD, CHIP_ERASE_B_CMD:
               begin
                  if (write_ok && core_r.write_latch_flag && core_r.protect_level[2:0] == 3'h0)
                  begin
                     core_nxt = start_op(core_nxt, OPK_CHIP, TIMER_W'(CHIP_ERASE_CYCLES - 1), 21'h000000,
                                         16'h0000);
                  end
               end
               SO_READY_SIGNAL_ON_CMD:
               begin
                  if (write_ok)
                  begin
                     core_nxt.hw_ready_en = 1'b1;
                  end
               end
               SO_READY_SIGNAL_OFF_CMD:
               begin
                  if (write_ok)
                  begin
                     core_nxt.hw_ready_en = 1'b0;
                  end
               end
               default: ;
            endcase
         end
      end
      core_nxt.device_status_and_protect = {core_nxt.protect_lock_bit, core_nxt.auto_increment_mode,
                                            core_nxt.protect_level, core_nxt.write_latch_flag,
                                            core_nxt.busy};
   end

   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
      begin
         core_r <= CORE_RESET;
      end
      else
      begin
         core_r <= core_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign so_out = out_r.so;
   assign so_oe = out_r.oe;
   assign array_req = core_r.req;
   assign status_out = core_r.device_status_and_protect;

endmodule : sfscd_top
`default_nettype wire

// file: tb/serial_flash_status_and_command_decode_test.sv
// Self-checking bench of the flash status and command decoder.
`timescale 1ns/10ps
`default_nettype none
`define CHK(name, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("unexpected %s expected %h seen %h", name, exp, got); \
      end \
   end
module serial_flash_status_and_command_decode_test
   import sfscd_pkg::*;
;
   typedef struct {logic [47:0] d; int nb; logic wp; logic [7:0] st;} sfscd_row_type;
   logic core_clk, arst_n, wp_n, sck, cs_n, si, so_out, so_oe;
   sfscd_req_type array_req;
   logic [7:0] status_out, rx;
   int errors = 0;
   int samples_checked = 0;
   sfscd_req_type last_req;
   int req_count = 0;
   // Latch set ahead of each write but one, whose latch-set frame stops at seven bits; the last rows lock the protection and try writes with the guard pin low.
   sfscd_row_type rows [$] = '{'{48'h06,8,1'h1,8'h1E}, '{48'h50,8,1'h1,8'h1E}, '{48'h0100,16,1'h1,8'h00},
      '{48'h06,8,1'h1,8'h02}, '{48'h02000010AA,40,1'h1,8'h00}, '{48'h06,8,1'h1,8'h02}, '{48'h20001000,32,1'h1,8'h00},
      '{48'h06,8,1'h1,8'h02}, '{48'h52008000,32,1'h1,8'h00}, '{48'h06,8,1'h1,8'h02}, '{48'hD8010000,32,1'h1,8'h00},
      '{48'h06,8,1'h1,8'h02}, '{48'h60,8,1'h1,8'h00}, '{48'h06,8,1'h1,8'h02}, '{48'hC7,8,1'h1,8'h00},
      '{48'h06,8,1'h1,8'h02}, '{48'h04,8,1'h1,8'h00}, '{48'h06,7,1'h1,8'h00}, '{48'h02000010AA,40,1'h1,8'h00},
      '{48'hFF,8,1'h1,8'h00}, '{48'h70,8,1'h1,8'h00}, '{48'h80,8,1'h1,8'h00}, '{48'h06,8,1'h1,8'h02},
      '{48'h010C,16,1'h1,8'h0C}, '{48'h06,8,1'h1,8'h0E}, '{48'h021F000055,40,1'h1,8'h0E}, '{48'h60,8,1'h1,8'h0E},
      '{48'h04,8,1'h1,8'h0C}, '{48'h06,8,1'h1,8'h0E}, '{48'h0100,16,1'h1,8'h00}, '{48'h06,8,1'h1,8'h02},
      '{48'hAD0000001122,48,1'h1,8'h42}, '{48'h20000000,32,1'h1,8'h42}, '{48'hAD3344,24,1'h1,8'h42},
      '{48'h04,8,1'h1,8'h00}, '{48'h06,8,1'h1,8'h02}, '{48'h018C,16,1'h1,8'h8C}, '{48'h06,8,1'h0,8'h8E},
      '{48'h0100,16,1'h0,8'h8C}, '{48'h06,8,1'h1,8'h8E}, '{48'h010C,16,1'h1,8'h0C}, '{48'h06,8,1'h0,8'h0E},
      '{48'h0194,16,1'h0,8'h94}};
   sfscd_top #(.PROG_CYCLES(20), .ERASE_CYCLES(40), .CHIP_ERASE_CYCLES(60)) i_dut (.core_clk(core_clk),
      .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
      .array_req(array_req), .status_out(status_out));
   sfscd_spi_host i_host (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe));
   always @(posedge core_clk)
   begin
      if (array_req.valid === 1'h1)
      begin
         last_req <= array_req;
         req_count <= req_count + 1;
      end
   end
   initial
   begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic do_reset();
      @(posedge core_clk);
      arst_n <= 1'h0;
      repeat (3) @(posedge core_clk);
      arst_n <= 1'h1;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      `CHK("status after reset", 8'h1C, status_out)
   endtask : do_reset
   // Lets busy appear, then waits for it to clear, giving up after a bounded count.
   task automatic settle();
      int n;
      n = 0;
      repeat (8) @(posedge core_clk);
      while (status_out[ST_BUSY] !== 1'h0 && n < 500)
      begin
         @(posedge core_clk);
         n++;
      end
      // Outputs are looked at half a cycle after the edge that launches them.
      @(negedge core_clk);
   endtask : settle
   task automatic send(input logic [47:0] d, input int nb);
      @(posedge core_clk);
      i_host.xfer(d, nb, rx);
      settle();
   endtask : send
   initial
   begin
      #500000;
      errors++;
      print_verdict();
   end
   initial
   begin
      arst_n = 1'h0;
      wp_n = 1'h1;
      do_reset();
      foreach (rows[i])
      begin
         @(posedge core_clk);
         wp_n <= rows[i].wp;
         i_host.xfer(rows[i].d, rows[i].nb, rx);
         settle();
         `CHK("status byte", rows[i].st, status_out)
      end
      `CHK("request count", 8, req_count)
      `CHK("last request", ({1'h1, OPK_AAI, 21'h000002, 16'h3344}), last_req)
      send(48'h70, 8);
      send(48'h06, 8);
      send(48'hAD0000005566, 48);
      `CHK("status in word mode", 8'hD6, status_out)
      send(48'h0500, 16);
      `CHK("ready on output", 8'hFF, rx)
      send(48'h80, 8);
      send(48'h04, 8);
      send(48'h80, 8);
      send(48'h06, 8);
      send(48'hAD0000107788, 48);
      send(48'h0500, 16);
      `CHK("status stream", 8'hD6, rx)
      send(48'h04, 8);
      i_host.mode3 = 1'h1;
      i_host.xfer(48'h0500, 16, rx);
      `CHK("status stream", 8'h94, rx)
      do_reset();
      print_verdict();
   end
endmodule : serial_flash_status_and_command_decode_test
`default_nettype wire

// file: tb/sfscd_spi_host.sv
// Host side of the serial link: select, clock and data in mode 0 or mode 3.
`timescale 1ns/10ps
`default_nettype none
module sfscd_spi_host
(
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so_out,
   input wire logic so_oe
);
   logic mode3 = 1'h0;
   initial
   begin
      sck = 1'h0;
      cs_n = 1'h1;
      si = 1'h0;
   end
   // Sends the low nb bits of d and keeps the last eight output bits; 64 ns stays under both rate limits.
   task automatic xfer(input logic [47:0] d, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      sck = mode3;
      #32 cs_n = 1'h0;
      for (int i = nb - 1; i >= 0; i--)
      begin
         #32 sck = 1'h0;
         si = d[i];
         #32 sck = 1'h1;
         // A released output is seen as the inverse of its last bit, so a missing drive shows.
         rx = {rx[6:0], so_oe ? so_out : ~so_out};
      end
      #32 sck = mode3;
      si = ~si;
      #32 cs_n = 1'h1;
      #64;
   endtask : xfer
endmodule : sfscd_spi_host
`default_nettype wire

// file: tb/sfscd_top_assertions.sv
// Checker of the status byte, the array requests and the output release of the decoder.
`timescale 1ns/10ps
`default_nettype none
module sfscd_top_checker
   import sfscd_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic so_oe,
   input wire sfscd_req_type array_req,
   input wire logic [7:0] status_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   busy_on_req_a: assert property (array_req.valid |-> status_out[ST_BUSY])
      else $error("busy missing with request");
   latch_need_a: assert property (array_req.valid |-> $past(status_out[1]))
      else $error("request without write latch");
   idle_req_a: assert property (array_req.valid |-> !$past(status_out[ST_BUSY]))
      else $error("request while busy");
   one_kind_a: assert property (array_req.valid |-> $onehot(array_req.kind) && array_req.kind != OPK_SPARE)
      else $error("bad request kind");
   chip_free_a: assert property (array_req.valid && array_req.kind == OPK_CHIP |-> $past(status_out[4:2]) == 3'h0)
      else $error("chip erase while protected");
   latch_drop_a: assert property ($fell(status_out[ST_BUSY]) && !status_out[ST_AAI] |-> !status_out[1])
      else $error("latch kept after operation");
   quiet_select_a: assert property ($changed({status_out[7], status_out[5:2]}) |-> cs_n)
      else $error("status changed inside frame");
   so_release_a: assert property (cs_n |-> !so_oe)
      else $error("output driven while deselected");
endmodule : sfscd_top_checker
bind sfscd_top sfscd_top_checker i_checker (.core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n), .so_oe(so_oe),
   .array_req(array_req), .status_out(status_out));
`default_nettype wire
